// [tb/erm_link_assertions.sv]
// Checker for the direct register link between the two ends.
// Assumes one clock and an active-low reset shared by both ends.
`timescale 1ns/10ps
module erm_link_assertions (
  input wire logic        sys_clk_i,
  input wire logic        rst_b_i,
  input wire logic        re,
  input wire logic        we,
  input wire logic [7:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic [15:0] rdata
);
  // ----------
  // Helper state
  // ----------
  logic [7:0] cnt_q;
  logic [7:0] era_q;
  logic       trg_q;
  logic       mnz_q;
  logic       clr_q;
  logic       trig;
  logic       rcs;
  assign trig = we && addr == erm_pkg::ADR_EXT_READ_CONTROL_STATUS && wdata[erm_pkg::EXT_READ_CONTROL_STATUS_TRIG_BIT];
  assign rcs  = re && addr[7:1] == 7'h06;

  // Cycles since a trigger, read address, margin select and a pending flag clear.
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_q <= 8'h00;
      era_q <= 8'h00;
      trg_q <= 1'b0;
      mnz_q <= 1'b0;
      clr_q <= 1'b0;
    end else begin
      cnt_q <= trig ? 8'h00 : (cnt_q == 8'hFF) ? cnt_q : cnt_q + 8'h01;
      trg_q <= trg_q | trig;
      era_q <= (we && addr[7:1] == 7'h05) ? wdata[7:0] : era_q;
      mnz_q <= (we && addr == erm_pkg::ADR_CTRL) ? (wdata[15:12] != 4'h0) : mnz_q;
      clr_q <= trig ? 1'b0 : (we && addr[7:1] == 7'h13 && wdata[7]) ? 1'b1 : clr_q;
    end
  end

  // ----------
  // Properties
  // ----------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);

  chk_strobe_excl: assert property (!(re && we))
    else $error("read and write strobes high together");
  chk_rdata_idle: assert property (!$past(re) |-> rdata == 16'h0000)
    else $error("read data outside its answer cycle");
  chk_odd_byte: assert property (re && addr[0] |=> rdata[15:8] == 8'h00)
    else $error("odd address read returned an upper byte");
  chk_nv_done_bound: assert property (trg_q && rcs && cnt_q >= 8'h54 |=> rdata[0])
    else $error("read not done within the time limit");
  chk_done_cleared: assert property (trg_q && rcs && cnt_q >= 8'h02 && cnt_q <= 8'h46
      && era_q < 8'h40 && !mnz_q |=> !rdata[0])
    else $error("done seen before the array read finished");
  chk_shadow_fast: assert property (trg_q && rcs && cnt_q >= 8'h04
      && era_q[7:6] == 2'b01 |=> rdata[0])
    else $error("shadow read not done promptly");
  chk_word_zeros: assert property (re && addr == erm_pkg::ADR_EXT_READ_DATA_HIGH |=> rdata[9:8] == 2'b00)
    else $error("unused result bits not zero");
  chk_warn_header: assert property (re && addr == erm_pkg::ADR_WARN
      |=> rdata[15:12] == erm_pkg::WARN_HEADER)
    else $error("warning register header wrong");
  chk_warn_cleared: assert property (re && addr == erm_pkg::ADR_WARN && clr_q |=> !rdata[7])
    else $error("access warning survived its clear");

  cover property (trig && era_q[7:6] == 2'b01);
  cover property (we && addr == erm_pkg::ADR_CTRL && wdata[15:12] == erm_pkg::MARGIN_HIGH);
  cover property (re && addr == erm_pkg::ADR_WARN ##1 rdata[7]);
endmodule // erm_link_assertions

// [tb/test_extended_read_and_margin_check.sv]
// Bench: both ends joined by the link; user port and array side driven here.
// Assumes the package constants; expectations come from the local array models.
`timescale 1ns/10ps
module test_extended_read_and_margin_check;
  // ----------
  // Signals, models and tasks
  // ----------
  logic        sys_clk_i;
  logic        rst_b_i;
  logic        unlocked_i;
  logic        sh_we_i;
  logic [5:0]  sh_addr_i;
  logic [23:0] sh_wdata_i;
  logic [31:0] nv_rdata_i;
  logic        nv_rd_o;
  logic [5:0]  nv_addr_o;
  logic [3:0]  nv_margin_o;
  logic [3:0]  usr_addr_i;
  logic [15:0] usr_wdata_i;
  logic        usr_we_i;
  logic        usr_re_i;
  logic [15:0] usr_rdata_o;
  logic [31:0] nvm [64];
  logic [23:0] shm [64];
  logic [31:0] wk0;
  logic [31:0] wk1;
  logic [15:0] seen_m;
  logic [15:0] rv;
  logic [7:0]  xs [8];
  int          miscompares;
  int          cmp_count;
  int          seed;

  erm_link_if erm_link_if_i ();
  erm_dev erm_dev_i (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .link(erm_link_if_i.dev_mp),
    .unlocked_i(unlocked_i), .sh_we_i(sh_we_i), .sh_addr_i(sh_addr_i), .sh_wdata_i(sh_wdata_i),
    .nv_rdata_i(nv_rdata_i), .nv_rd_o(nv_rd_o), .nv_addr_o(nv_addr_o),
    .nv_margin_o(nv_margin_o));
  erm_ctl erm_ctl_i (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .link(erm_link_if_i.ctl_mp),
    .usr_addr_i(usr_addr_i), .usr_wdata_i(usr_wdata_i), .usr_we_i(usr_we_i),
    .usr_re_i(usr_re_i), .usr_rdata_o(usr_rdata_o));
  erm_link_assertions erm_link_assertions_i (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
    .re(erm_link_if_i.re), .we(erm_link_if_i.we), .addr(erm_link_if_i.addr),
    .wdata(erm_link_if_i.wdata), .rdata(erm_link_if_i.rdata));

  // Clock of 25 ns.
  initial begin
    sys_clk_i = 1'b0;
    forever #12.5 sys_clk_i = ~sys_clk_i;
  end

  // Array model: margin level moves the threshold; an idle data bus shows flipped data.
  always @(posedge sys_clk_i) begin
    if (nv_rd_o) begin
      seen_m[nv_margin_o] <= 1'b1;
      case (nv_margin_o)
        erm_pkg::MARGIN_LOW:  nv_rdata_i <= nvm[nv_addr_o] | wk0;
        erm_pkg::MARGIN_HIGH: nv_rdata_i <= nvm[nv_addr_o] & ~wk1;
        default:              nv_rdata_i <= nvm[nv_addr_o];
      endcase
    end else begin
      nv_rdata_i <= ~nv_rdata_i;
    end
  end

  // Expected word for an extended address.
  function automatic logic [31:0] expw(input logic [7:0] a);
    if (a < 8'h40) return {nvm[a[5:0]][31:26], 2'b00, nvm[a[5:0]][23:0]};
    if (a < 8'h80) return {8'h00, shm[a[5:0]]};
    return 32'h0;
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] e);
    cmp_count++;
    if (seen !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk_i);
    usr_addr_i <= a;
    usr_wdata_i <= d;
    usr_we_i <= 1'b1;
    @(posedge sys_clk_i);
    usr_we_i <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge sys_clk_i);
    usr_addr_i <= a;
    usr_re_i <= 1'b1;
    @(posedge sys_clk_i);
    usr_re_i <= 1'b0;
    @(negedge sys_clk_i);
    v = usr_rdata_o;
  endtask

  // Starts a command and polls status until it is done, with a bound.
  task automatic run(input logic [7:0] xa, input logic [15:0] cmd, input logic [31:0] e);
    int n;
    n = 0;
    wr(erm_pkg::CR_XADDR, {8'h00, xa});
    wr(erm_pkg::CR_EXP_HI, e[31:16]);
    wr(erm_pkg::CR_EXP_LO, e[15:0]);
    wr(erm_pkg::CR_CMD, cmd);
    do begin
      rd(erm_pkg::CR_CMD, rv);
      n++;
      if (n > 3000) begin
        miscompares++;
        $display("mismatch completion expected done seen busy");
        conclude();
      end
    end while (rv[0] !== 1'b0 || rv[1] !== 1'b1);
  endtask

  task automatic res_chk(input logic [31:0] e);
    logic [15:0] hi;
    logic [15:0] lo;
    rd(erm_pkg::CR_RES_HI, hi);
    rd(erm_pkg::CR_RES_LO, lo);
    chk("result", {hi, lo}, e);
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Main sequence.
  initial begin
    seed = 32'hb3702851;
    {rst_b_i, sh_we_i, usr_we_i, usr_re_i, sh_addr_i, sh_wdata_i} = '0;
    {usr_addr_i, usr_wdata_i, nv_rdata_i, wk0, wk1, seen_m} = '0;
    unlocked_i = 1'b1;
    miscompares = 0;
    cmp_count = 0;
    for (int i = 0; i < 64; i++) begin
      nvm[i] = $random(seed);
      shm[i] = 24'($random(seed));
    end
    repeat (16) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    rd(erm_pkg::CR_CMD, rv);
    chk("status after reset", {16'h0, rv}, 32'h0);
    chk("margin after reset", {28'h0, nv_margin_o}, 32'h0);
    for (int i = 0; i < 64; i++) begin
      @(posedge sys_clk_i);
      sh_we_i <= 1'b1;
      sh_addr_i <= 6'(i);
      sh_wdata_i <= shm[i];
    end
    @(posedge sys_clk_i);
    sh_we_i <= 1'b0;
    $display("test reset and shadow load done");
    xs = '{8'h00, 8'h3F, 8'h40, 8'h7F, 8'h80, 8'hFF, 8'h00, 8'h40};
    xs[6] = {2'b00, 6'($random(seed))};
    xs[7] = {2'b01, 6'($random(seed))};
    foreach (xs[i]) begin
      run(xs[i], 16'h0001, 32'h0);
      res_chk(expw(xs[i]));
    end
    $display("test extended reads done");
    seen_m = 16'h0;
    run(8'h1F, 16'h0002, expw(8'h1F));
    chk("margin pass status", {28'h0, rv[3:0]}, 32'h2);
    chk("margin levels used", {16'h0, seen_m}, 32'h6);
    chk("margin restored", {28'h0, nv_margin_o}, 32'h0);
    for (int k = 0; k < 2; k++) begin
      wk0 = (k == 0) ? 32'h10 : 32'h0;
      wk1 = (k == 1) ? 32'h20 : 32'h0;
      nvm[31] = (nvm[31] & ~wk0) | wk1;
      run(8'h1F, 16'h0002, expw(8'h1F));
      chk("margin fail status", {28'h0, rv[3:0]}, 32'h6);
    end
    wk0 = 32'h0;
    wk1 = 32'h0;
    $display("test margin check done");
    @(posedge sys_clk_i);
    unlocked_i <= 1'b0;
    run(8'h1F, 16'h0002, expw(8'h1F));
    chk("locked margin warning", {31'h0, rv[3]}, 32'h1);
    @(posedge sys_clk_i);
    unlocked_i <= 1'b1;
    run(8'h05, 16'h0001, 32'h0);
    res_chk(expw(8'h05));
    $display("test locked margin done");
    conclude();
  end
endmodule // test_extended_read_and_margin_check

// [verilog/erm_ctl.sv]
// Controller end: runs extended reads and the two-threshold margin check.
// Assumes the device answers link reads in the next cycle and the array is unlocked.
//
// The plain strobed port was left to the implementer.
`timescale 1ns/10ps
module erm_ctl (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_b_i,
  erm_link_if.ctl_mp       link,
  input  wire logic [3:0]  usr_addr_i,
  input  wire logic [15:0] usr_wdata_i,
  input  wire logic        usr_we_i,
  input  wire logic        usr_re_i,
  output logic [15:0]      usr_rdata_o
);

  // -----------------------------------------------------------------------
  // State.
  // -----------------------------------------------------------------------
  typedef enum logic [11:0] {
    S_IDLE  = 12'h001, S_CLR   = 12'h002, S_MSET  = 12'h004, S_FLAG  = 12'h008,
    S_FLAGW = 12'h010, S_ADDR  = 12'h020, S_TRIG  = 12'h040, S_POLL  = 12'h080,
    S_POLLW = 12'h100, S_DHI   = 12'h200, S_DLO   = 12'h400, S_CHK   = 12'h800
  } erm_ctl_state_t;

  typedef struct packed {
    erm_ctl_state_t st;
    logic           margin_op;
    logic [3:0]     mode;
    logic [7:0]     xaddr;
    logic [31:0]    expect_w;
    logic [31:0]    res;
    logic           busy;
    logic           done;
    logic           fail;
    logic           warn;
    logic           re;
    logic           we;
    logic [7:0]     addr;
    logic [15:0]    wdata;
    logic [15:0]    urd;
    logic           wt;  // Set in the cycle the awaited read answer is on rdata.
  } erm_ctl_st_t;

  erm_ctl_st_t q;
  erm_ctl_st_t d;

  // -----------------------------------------------------------------------
  // Next-state logic: user registers and the link sequencer.
  // -----------------------------------------------------------------------
  always_comb begin
    d       = q;
    d.re    = 1'b0;
    d.we    = 1'b0;
    d.urd   = 16'h0000;

    // User register reads answer one cycle later.
    if (usr_re_i) begin
      case (usr_addr_i)
        erm_pkg::CR_CMD:    d.urd = {12'h000, q.warn, q.fail, q.done, q.busy};
        erm_pkg::CR_XADDR:  d.urd = {8'h00, q.xaddr};
        erm_pkg::CR_EXP_HI: d.urd = q.expect_w[31:16];
        erm_pkg::CR_EXP_LO: d.urd = q.expect_w[15:0];
        erm_pkg::CR_RES_HI: d.urd = q.res[31:16];
        erm_pkg::CR_RES_LO: d.urd = q.res[15:0];
        default:            d.urd = 16'h0000;
      endcase
    end

    case (q.st)
      S_IDLE: begin
        if (usr_we_i) begin
          case (usr_addr_i)
            erm_pkg::CR_XADDR:  d.xaddr = usr_wdata_i[7:0];
            erm_pkg::CR_EXP_HI: d.expect_w[31:16] = usr_wdata_i;
            erm_pkg::CR_EXP_LO: d.expect_w[15:0] = usr_wdata_i;
            erm_pkg::CR_CMD: begin
              if (usr_wdata_i[erm_pkg::CMD_MARGIN_BIT]) begin
                d.margin_op = 1'b1;
                d.mode      = erm_pkg::MARGIN_LOW;
                d.st        = S_CLR;
              end else if (usr_wdata_i[erm_pkg::CMD_READ_BIT]) begin
                d.margin_op = 1'b0;
                d.st        = S_ADDR;
              end
              if (usr_wdata_i[erm_pkg::CMD_MARGIN_BIT] || usr_wdata_i[erm_pkg::CMD_READ_BIT]) begin
                d.busy = 1'b1;
                d.done = 1'b0;
                d.fail = 1'b0;
                d.warn = 1'b0;
              end
            end
            default: ;
          endcase
        end
      end
      S_CLR: begin
        d.we    = 1'b1;
        d.addr  = erm_pkg::ADR_WARN;
        d.wdata = 16'hFFFF;
        d.st    = S_MSET;
      end
      S_MSET: begin
        d.we    = 1'b1;
        d.addr  = erm_pkg::ADR_CTRL;
        d.wdata = {q.mode, 4'h0, erm_pkg::CONFIRM_CODE};
        d.st    = S_FLAG;
      end
      S_FLAG: begin
        d.re   = 1'b1;
        d.addr = erm_pkg::ADR_WARN;
        d.st   = S_FLAGW;
      end
      S_FLAGW: begin
        if (!q.wt) begin
          d.wt = 1'b1;  // The strobe is on the link now; its answer comes next cycle.
        end else begin
          d.wt = 1'b0;
          if ((link.rdata & erm_pkg::WARN_COMM_MASK) != 16'h0000) begin
            d.warn = 1'b1;
          end
          if (q.mode == erm_pkg::MARGIN_NORMAL) begin
            d.busy = 1'b0;
            d.done = 1'b1;
            d.st   = S_IDLE;
          end else begin
            d.st = S_ADDR;
          end
        end
      end
      S_ADDR: begin
        d.we    = 1'b1;
        d.addr  = erm_pkg::ADR_ERA;
        d.wdata = {8'h00, q.xaddr};
        d.st    = S_TRIG;
      end
      S_TRIG: begin
        d.we    = 1'b1;
        d.addr  = erm_pkg::ADR_EXT_READ_CONTROL_STATUS;
        d.wdata = 16'h8000;
        d.st    = S_POLL;
      end
      S_POLL: begin
        d.re   = 1'b1;
        d.addr = erm_pkg::ADR_EXT_READ_CONTROL_STATUS | 8'h01;
        d.st   = S_POLLW;
      end
      S_POLLW: begin
        if (!q.wt) begin
          d.wt = 1'b1;
        end else begin
          d.wt = 1'b0;
          d.st = link.rdata[erm_pkg::EXT_READ_CONTROL_STATUS_DONE_BIT] ? S_DHI : S_POLL;
        end
      end
      S_DHI: begin
        d.re   = 1'b1;
        d.addr = erm_pkg::ADR_EXT_READ_DATA_HIGH;
        d.st   = S_DLO;
      end
      S_DLO: begin
        d.re   = 1'b1;
        d.addr = erm_pkg::ADR_EXT_READ_DATA_LOW;
        d.st   = S_CHK;
      end
      S_CHK: begin
        if (!q.wt) begin
          d.wt         = 1'b1;
          d.res[31:16] = link.rdata;
        end else begin
          d.wt        = 1'b0;
          d.res[15:0] = link.rdata;
          if (q.margin_op) begin
            if ({q.res[31:16], link.rdata} != q.expect_w) begin
              d.fail = 1'b1;
            end
            d.mode = (q.mode == erm_pkg::MARGIN_LOW) ? erm_pkg::MARGIN_HIGH
                                                     : erm_pkg::MARGIN_NORMAL;
            d.st   = S_MSET;
          end else begin
            d.busy = 1'b0;
            d.done = 1'b1;
            d.st   = S_IDLE;
          end
        end
      end
      default: d.st = S_IDLE;
    endcase
  end

  // -----------------------------------------------------------------------
  // State register.
  // -----------------------------------------------------------------------
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q    <= '0;
      q.st <= S_IDLE;
    end else begin
      q <= d;
    end
  end

  // -----------------------------------------------------------------------
  // Outputs straight from the state register.
  // -----------------------------------------------------------------------
  assign link.re     = q.re;
  assign link.we     = q.we;
  assign link.addr   = q.addr;
  assign link.wdata  = q.wdata;
  assign usr_rdata_o = q.urd;

endmodule  // erm_ctl

// [verilog/erm_dev.sv]
// Device end: direct registers, extended read engine, margin select, shadow store.
// Assumes link strobes are synchronous to sys_clk_i and never both high at once.
//
// Behaviour
// - Controller margin-checks cells after programming them.
// - Select 0001 lowers the read threshold.
// - Select 0010 raises the read threshold.
// - Controller writes select then confirm 0xA5; this controller sends both in one write.
// - Margin values stay held and read back.
// - Select 0000 or reset restores normal threshold.
// - Controller clears error and warning flags first.
// - Controller checks communication flags after each step; this controller checks them only after each margin select write.
// - Controller rewrites and rechecks on mismatch; this controller only sets fail and goes on.
// - Extended locations are up to 32 bits.
// - Read address is 8 bits at 0x0B.
// - Trigger bit write starts the extended read.
// - Nonvolatile read done within 2 us.
// - Done bit is bit 0 of next byte.
// - Shadow read completes one cycle after request.
// - Controller reads data only after done.
// - Result split into high and low halves.
// - Nonvolatile word: check code, zeros, data.
// - New command accepted during previous response; this engine drops a trigger while busy.
// - Shadow sits 0x40 above nonvolatile address.
// - Margin checking needs the array unlocked.
// - Violation ends read, sets done and warning.
`timescale 1ns/10ps
module erm_dev (
  input  wire logic           sys_clk_i,
  input  wire logic           rst_b_i,
  erm_link_if.dev_mp          link,
  input  wire logic           unlocked_i,
  input  wire logic           sh_we_i,
  input  wire logic [5:0]     sh_addr_i,
  input  wire logic [23:0]    sh_wdata_i,
  input  wire logic [31:0]    nv_rdata_i,
  output logic                nv_rd_o,
  output logic [5:0]          nv_addr_o,
  output logic [3:0]          nv_margin_o
);

  // -----------------------------------------------------------------------
  // State.
  // -----------------------------------------------------------------------
  // The read engine holds busy for the whole array access and only then raises done,
  // so a poll of the status byte never sees a half-loaded result.
  // A trigger that arrives while busy is dropped, since a restart would tear the result.
  // The shadow words sit in the state as a packed array, so one register holds all.
  typedef struct packed {
    logic [7:0]                                       ext_read_address;
    logic                                             busy;
    logic                                             done;
    logic [1:0]                                       src;
    logic [6:0]                                       cnt;
    logic [7:0]                                       rd_addr;
    logic [31:0]                                      extended_read_data_registers;
    logic [3:0]                                       pend;
    logic [3:0]                                       margin;
    logic                                             extended_access_warning;
    logic [15:0]                                      rdata;
    logic                                             nv_rd;
    logic [erm_pkg::SHADOW_WORDS-1:0][erm_pkg::SHADOW_BITS-1:0] shadow;
  } erm_dev_st_t;

  erm_dev_st_t q;
  erm_dev_st_t d;
  logic [7:0]  wa;
  logic [15:0] rword;
  logic        start;
  logic [3:0]  spec;

  // -----------------------------------------------------------------------
  // Next-state logic: register reads, register writes, then the engine.
  // -----------------------------------------------------------------------
  always_comb begin
    d     = q;
    wa    = {link.addr[7:1], 1'b0};
    start = 1'b0;
    spec  = link.wdata[erm_pkg::CTRL_SPEC_LSB +: 4];

    // Word view of the addressed register pair.
    rword = 16'h0000;
    case (wa)
      erm_pkg::ADR_ERA:  rword = {8'h00, q.ext_read_address};
      erm_pkg::ADR_EXT_READ_CONTROL_STATUS: begin
        rword[erm_pkg::EXT_READ_CONTROL_STATUS_BUSY_BIT] = q.busy;
        rword[erm_pkg::EXT_READ_CONTROL_STATUS_DONE_BIT] = q.done;
      end
      erm_pkg::ADR_EXT_READ_DATA_HIGH: rword = q.extended_read_data_registers[31:16];
      erm_pkg::ADR_EXT_READ_DATA_LOW: rword = q.extended_read_data_registers[15:0];
      erm_pkg::ADR_CTRL: rword = {q.pend, 12'h000};
      erm_pkg::ADR_WARN: begin
        rword[15:12]                 = erm_pkg::WARN_HEADER;
        rword[erm_pkg::WARN_XEE_BIT] = q.extended_access_warning;
      end
      default:           rword = 16'h0000;
    endcase

    // Read data stand only in the cycle after the strobe; odd reads give one byte.
    d.rdata = 16'h0000;
    if (link.re) begin
      d.rdata = link.addr[0] ? {8'h00, rword[7:0]} : rword;
    end

    // Register writes.
    // A confirm byte applies the pending select; a select of 0000 alone returns the
    // threshold to normal, while selects 0001 and 0010 wait for the confirm byte.
    if (link.we) begin
      case (wa)
        erm_pkg::ADR_ERA:  d.ext_read_address = link.wdata[7:0];
        erm_pkg::ADR_EXT_READ_CONTROL_STATUS: begin
          if (!link.addr[0] && link.wdata[erm_pkg::EXT_READ_CONTROL_STATUS_TRIG_BIT]) begin
            start = 1'b1;
          end
        end
        erm_pkg::ADR_CTRL: begin
          if (!link.addr[0]) begin
            if (spec == erm_pkg::MARGIN_NORMAL) begin
              d.pend   = erm_pkg::MARGIN_NORMAL;
              d.margin = erm_pkg::MARGIN_NORMAL;
            end else if (spec == erm_pkg::MARGIN_LOW || spec == erm_pkg::MARGIN_HIGH) begin
              d.pend = spec;
            end
          end
          if (link.wdata[7:0] == erm_pkg::CONFIRM_CODE) begin
            d.margin = d.pend;
          end
        end
        erm_pkg::ADR_WARN: begin
          if (link.wdata[erm_pkg::WARN_XEE_BIT]) begin
            d.extended_access_warning = 1'b0;
          end
        end
        default: ;
      endcase
    end

    // Shadow store loading from the user side.
    if (sh_we_i) begin
      d.shadow[sh_addr_i] = sh_wdata_i;
    end

    // Read engine; it comes last so a hardware set beats a software clear.
    if (q.busy) begin
      if (q.cnt == 7'h00) begin
        d.busy  = 1'b0;
        d.done  = 1'b1;
        d.nv_rd = 1'b0;
        if (q.src == erm_pkg::SEG_NV) begin
          d.extended_read_data_registers = {nv_rdata_i[31:26], 2'b00, nv_rdata_i[23:0]};
        end else begin
          d.extended_read_data_registers = {8'h00, q.shadow[q.rd_addr[5:0]]};
        end
      end else begin
        d.cnt = q.cnt - 7'h01;
      end
    end else if (start) begin
      d.done    = 1'b0;
      d.rd_addr = q.ext_read_address;
      case (q.ext_read_address[7:6])
        erm_pkg::SEG_NV: begin
          if (q.margin != erm_pkg::MARGIN_NORMAL && !unlocked_i) begin
            d.done = 1'b1;
            d.extended_access_warning  = 1'b1;
          end else begin
            d.busy  = 1'b1;
            d.src   = erm_pkg::SEG_NV;
            d.nv_rd = 1'b1;
            d.cnt   = 7'(erm_pkg::NV_READ_CYC - 1);
          end
        end
        erm_pkg::SEG_SHADOW: begin
          d.busy = 1'b1;
          d.src  = erm_pkg::SEG_SHADOW;
          d.cnt  = 7'h00;
        end
        default: begin
          d.done = 1'b1;
          d.extended_read_data_registers  = 32'h0000_0000;
        end
      endcase
    end
  end

  // -----------------------------------------------------------------------
  // State register; reset also returns the threshold to normal.
  // -----------------------------------------------------------------------
  // Reset also empties the shadow store, which the user side must load again.
  // Reads of it before that return zero data words.
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // -----------------------------------------------------------------------
  // Outputs straight from the state register.
  // -----------------------------------------------------------------------
  // The threshold output follows the confirmed margin only; the pending select is
  // what software reads back.
  assign link.rdata  = q.rdata;
  assign nv_rd_o     = q.nv_rd;
  assign nv_addr_o   = q.rd_addr[5:0];
  assign nv_margin_o = q.margin;

endmodule  // erm_dev

// [verilog/erm_link_if.sv]
// Direct register link between the external controller and the device.
// Assumes both ends run on the same clock; the device answers reads a cycle later.
`timescale 1ns/10ps
interface erm_link_if;
  logic        re;     // Read strobe.
  logic        we;     // Write strobe.
  logic [7:0]  addr;   // Byte address; even moves 16 bits, odd moves the low byte.
  logic [15:0] wdata;
  logic [15:0] rdata;  // Valid in the cycle after re.

  modport dev_mp (input re, input we, input addr, input wdata, output rdata);
  modport ctl_mp (output re, output we, output addr, output wdata, input rdata);
endinterface

// [verilog/erm_pkg.sv]
// Shared constants of the extended read engine and its controller.
// Assumes one 40 MHz system clock on both ends of the direct register link.
package erm_pkg;

  // ---------------------------------------------------------------------
  // Direct register byte addresses on the link.
  // ---------------------------------------------------------------------
  localparam logic [7:0] ADR_ERA  = 8'h0A;  // ext_read_address, low byte at 0x0B.
  localparam logic [7:0] ADR_EXT_READ_CONTROL_STATUS = 8'h0C;  // ext_read_control_status.
  localparam logic [7:0] ADR_EXT_READ_DATA_HIGH = 8'h0E;  // ext_read_data_high.
  localparam logic [7:0] ADR_EXT_READ_DATA_LOW = 8'h10;  // ext_read_data_low.
  localparam logic [7:0] ADR_CTRL = 8'h1E;  // Margin select and confirm.
  localparam logic [7:0] ADR_WARN = 8'h26;  // Warning flags.

  // ---------------------------------------------------------------------
  // Field positions and values.
  // ---------------------------------------------------------------------
  localparam int         EXT_READ_CONTROL_STATUS_TRIG_BIT   = 15;
  localparam int         EXT_READ_CONTROL_STATUS_BUSY_BIT   = 8;
  localparam int         EXT_READ_CONTROL_STATUS_DONE_BIT   = 0;
  localparam int         CTRL_SPEC_LSB   = 12;
  localparam logic [7:0] CONFIRM_CODE    = 8'hA5;
  localparam logic [3:0] MARGIN_NORMAL   = 4'h0;
  localparam logic [3:0] MARGIN_LOW      = 4'h1;
  localparam logic [3:0] MARGIN_HIGH     = 4'h2;
  localparam logic [3:0] WARN_HEADER     = 4'hB;
  localparam int         WARN_XEE_BIT    = 7;
  localparam logic [15:0] WARN_COMM_MASK = 16'h0CA4;  // COMM_WARNING_FLAG_C, CRC, EXTENDED_ACCESS_WARNING, COMM_WARNING_FLAG_A, BSY.
  localparam logic [1:0] SEG_NV          = 2'h0;
  localparam logic [1:0] SEG_SHADOW      = 2'h1;    // Extended address 0x40..0x7F.
  localparam int         SHADOW_WORDS    = 64;
  localparam int         SHADOW_BITS     = 24;

  // ---------------------------------------------------------------------
  // Timing: a nonvolatile read finishes within 2 us.
  // ---------------------------------------------------------------------
  localparam int         CLK_PERIOD_NS   = 25;
  localparam int         NV_READ_MAX_NS  = 2000;
  localparam int         NV_READ_CYC     = NV_READ_MAX_NS / CLK_PERIOD_NS;

  // ---------------------------------------------------------------------
  // Controller user registers (4-bit word index).
  // ---------------------------------------------------------------------
  localparam logic [3:0] CR_CMD    = 4'h0;  // W: bit0 read, bit1 margin check.
  localparam logic [3:0] CR_XADDR  = 4'h1;
  localparam logic [3:0] CR_EXP_HI = 4'h2;
  localparam logic [3:0] CR_EXP_LO = 4'h3;
  localparam logic [3:0] CR_RES_HI = 4'h4;
  localparam logic [3:0] CR_RES_LO = 4'h5;
  localparam int         CMD_READ_BIT   = 0;
  localparam int         CMD_MARGIN_BIT = 1;

endpackage
